// ### hw/eewr_consts.svh
// Purpose: Shared constants of the serial memory write path
// Assumes: mclk runs at EEWR_MCLK_MHZ
// Notes:   Cycle counts derive from the printed times
`ifndef EEWR_CONSTS_SVH
`define EEWR_CONSTS_SVH

// =====================================================================
// Bus address and array layout
`define EEWR_DEV_TYPE       4'hA
`define EEWR_ADDR_W         12
`define EEWR_PAGE_BYTES     32
`define EEWR_OFS_W          5
`define EEWR_ERASED         8'hFF

// =====================================================================
// Timing
`define EEWR_MCLK_MHZ       100
`define EEWR_PROG_TIME_MS   5
`define EEWR_PU_TIME_MS     1
`define EEWR_PROG_CYCLES    (`EEWR_PROG_TIME_MS * 1000 * `EEWR_MCLK_MHZ)
`define EEWR_PU_CYCLES      (`EEWR_PU_TIME_MS * 1000 * `EEWR_MCLK_MHZ)

`endif

// ### hw/eewr_pkg.sv
// Purpose: Types of the serial memory write path
// Assumes: Nothing beyond the constants header
// Notes:   State enums only
package eewr_pkg;

    // =================================================================
    // Link-side protocol states
    typedef enum logic [2:0]
    {
        LS_IDLE,
        LS_DEV,
        LS_ADDR_HI,
        LS_ADDR_LO,
        LS_DATA,
        LS_IGNORE
    } eewr_link_state_e;

    // =================================================================
    // Programming engine states
    typedef enum logic [1:0]
    {
        PS_IDLE,
        PS_COPY,
        PS_WAIT
    } eewr_prog_state_e;

endpackage : eewr_pkg

// ### hw/eewr_write_path.sv
// Purpose: Two-wire slave write path of a byte-organised nonvolatile memory
// Assumes: lclk oversamples scl/sda; reset models the power-on detector
// Notes:   Read transfers are not handled; a read address byte is refused
//
// Summary of operation
// - Leaving reset, the device idles and waits for a START once powered up.
// - Reset at any time abandons transfers and returns the control logic to reset; the array keeps its contents.
// - Zero is sent by pulling SDA low, one by releasing it.
// - SDA sampled on SCL rise, changed after SCL fall, open-drain output.
// - SDA held stable while SCL high; changes only while SCL low.
// - SDA fall with SCL high is START; nothing is answered before one.
// - SDA rise with SCL high is STOP and ends the current command.
// - Address byte must be 1010 then the three strap levels to respond.
// - Address byte LSB gives direction: one read, zero write.
// - Ninth clock: transmitter releases SDA, receiver pulls low to acknowledge.
// - Write is address, two memory address bytes, data, STOP; all acknowledged.
// - STOP after a write starts programming; no acknowledge while it runs.
// - Up to 32 data bytes are buffered from the given start address.
// - Page latched, offset increments and wraps in page, later bytes overwrite.
// - After STOP all buffered bytes commit together in one programming cycle.
// - Write-protect high blocks writes; low lets writes proceed.
// - Write-protect sampled on the SCL fall just before the first data byte.
// - Protected write refuses the first data byte and starts no programming.
// - Unconnected straps and write-protect read as low.
// - Every array byte starts at the erased value FFh.
// - Bus commands refused until 1 ms after power becomes stable.
`include "eewr_consts.svh"

module eewr_write_path
    import eewr_pkg::*;
#(
    parameter int PROG_CYCLES = `EEWR_PROG_CYCLES,
    parameter int PU_CYCLES   = `EEWR_PU_CYCLES,
    parameter int MEM_BYTES   = 4096
)
(
    // Clocks and power-on reset
    input  wire logic                    mclk,
    input  wire logic                    lclk,
    input  wire logic                    reset,
    // Two-wire bus pins
    input  wire logic                    scl_in,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe_n,
    // Strap and protect pins
    input  wire logic                    strap_addr_bit0,
    input  wire logic                    strap_addr_bit1,
    input  wire logic                    strap_addr_bit2,
    input  wire logic                    write_protect,
    // Status
    output logic                         dev_ready,
    output logic                         prog_busy,
    // Array inspection port
    input  wire logic [`EEWR_ADDR_W-1:0] peek_addr,
    output logic [7:0]                   peek_data
);

    localparam int PG_W = `EEWR_ADDR_W - `EEWR_OFS_W;
    localparam int PC_W = $clog2(PROG_CYCLES + 1);
    localparam int PU_W = $clog2(PU_CYCLES + 1);

    // =================================================================
    // Link domain: reset and pin synchronisers
    logic                   lrst_meta_reg;
    logic                   lrst_reg;
    logic [1:0]             scl_sync_reg;
    logic [1:0]             sda_sync_reg;
    logic [3:0]             pin_meta_reg;
    logic [3:0]             pin_sync_reg;
    logic                   ready_meta_reg;
    logic                   ready_l_reg;
    logic                   ack_meta_reg;
    logic                   ack_l_reg;
    logic                   ack_tgl_reg;
    logic                   scl_q_reg;
    logic                   sda_q_reg;

    // Reset reaches the link clock through two flops
    always_ff @(posedge lclk)
    begin
        lrst_meta_reg <= reset;
        lrst_reg      <= lrst_meta_reg;
    end

    always_ff @(posedge lclk)
    begin
        scl_sync_reg[0] <= scl_in;
        scl_sync_reg[1] <= scl_sync_reg[0];
        sda_sync_reg[0] <= sda_in;
        sda_sync_reg[1] <= sda_sync_reg[0];
        pin_meta_reg    <= {write_protect, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
        pin_sync_reg    <= pin_meta_reg;
        ready_meta_reg  <= dev_ready;
        ready_l_reg     <= ready_meta_reg;
        ack_meta_reg    <= ack_tgl_reg;
        ack_l_reg       <= ack_meta_reg;
        scl_q_reg       <= scl_sync_reg[1];
        sda_q_reg       <= sda_sync_reg[1];
    end

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_s     = scl_sync_reg[1];
    assign sda_s     = sda_sync_reg[1];
    assign scl_rise  = scl_s & ~scl_q_reg;
    assign scl_fall  = ~scl_s & scl_q_reg;
    assign bus_start = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    assign bus_stop  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

    // =================================================================
    // Link domain: bit and byte framing
    logic [3:0]             bit_cnt_reg;
    logic                   ack_phase_reg;
    logic [7:0]             shift_reg;
    logic                   byte_done;
    logic                   ack_end;

    assign byte_done = scl_fall & ~ack_phase_reg & (bit_cnt_reg == 4'h8);
    assign ack_end   = scl_fall & ack_phase_reg;

    always_ff @(posedge lclk)
    begin
        if (lrst_reg || bus_start || bus_stop)
        begin
            bit_cnt_reg   <= 4'h0;
            ack_phase_reg <= 1'b0;
        end
        else if (scl_rise && !ack_phase_reg && bit_cnt_reg != 4'h8)
        begin
            shift_reg   <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        else if (byte_done)
        begin
            ack_phase_reg <= 1'b1;
        end
        else if (ack_end)
        begin
            ack_phase_reg <= 1'b0;
            bit_cnt_reg   <= 4'h0;
        end
    end

    // =================================================================
    // Link domain: protocol state and addressing
    eewr_link_state_e       lstate_reg;
    logic [3:0]             addr_hi_reg;
    logic [PG_W-1:0]        page_reg;
    logic [`EEWR_OFS_W-1:0] ofs_reg;
    logic                   wp_hold_reg;
    logic [`EEWR_PAGE_BYTES-1:0] mask_reg;
    logic [7:0]             page_buf [0:`EEWR_PAGE_BYTES-1];
    logic                   req_tgl_reg;
    logic                   busy_l;
    logic                   addr_match;
    logic                   ack_ok;

    assign busy_l     = req_tgl_reg ^ ack_l_reg;
    // Floating straps are pulled low at the pad, so they simply read zero
    assign addr_match = (shift_reg[7:4] == `EEWR_DEV_TYPE)
                        && (shift_reg[3:1] == pin_sync_reg[2:0]);

    always_comb
    begin
        case (lstate_reg)
            // Reads are outside this block, so a read address is refused
            LS_DEV:     ack_ok = addr_match && !shift_reg[0] && !busy_l;
            LS_ADDR_HI: ack_ok = 1'b1;
            LS_ADDR_LO: ack_ok = 1'b1;
            LS_DATA:    ack_ok = !wp_hold_reg;
            default:    ack_ok = 1'b0;
        endcase
    end

    always_ff @(posedge lclk)
    begin
        if (lrst_reg)
            lstate_reg <= LS_IDLE;
        else if (bus_start)
        begin
            // No START is honoured before power-up has settled
            lstate_reg <= ready_l_reg ? LS_DEV : LS_IDLE;
        end
        else if (bus_stop)
            lstate_reg <= LS_IDLE;
        else if (byte_done)
        begin
            case (lstate_reg)
                LS_DEV:     lstate_reg <= ack_ok ? LS_ADDR_HI : LS_IGNORE;
                LS_ADDR_HI: lstate_reg <= LS_ADDR_LO;
                LS_ADDR_LO: lstate_reg <= LS_DATA;
                LS_DATA:    lstate_reg <= ack_ok ? LS_DATA : LS_IGNORE;
                default:    lstate_reg <= lstate_reg;
            endcase
        end
    end

    always_ff @(posedge lclk)
    begin
        if (lrst_reg)
        begin
            addr_hi_reg <= 4'h0;
            page_reg    <= '0;
            ofs_reg     <= '0;
        end
        else if (byte_done && lstate_reg == LS_ADDR_HI)
            addr_hi_reg <= shift_reg[3:0];
        else if (byte_done && lstate_reg == LS_ADDR_LO)
        begin
            page_reg <= {addr_hi_reg, shift_reg[7:`EEWR_OFS_W]};
            ofs_reg  <= shift_reg[`EEWR_OFS_W-1:0];
        end
        else if (byte_done && lstate_reg == LS_DATA && ack_ok)
            ofs_reg <= ofs_reg + 1'b1;
    end

    // Protect level is caught once, on the fall that ends the address ack
    always_ff @(posedge lclk)
    begin
        if (lrst_reg || bus_start)
            wp_hold_reg <= 1'b0;
        else if (ack_end && lstate_reg == LS_DATA && mask_reg == '0)
            wp_hold_reg <= pin_sync_reg[3];
    end

    // Buffer stays frozen while busy, so the engine may read it across domains
    always_ff @(posedge lclk)
    begin
        if (lrst_reg || (bus_start && !busy_l))
            mask_reg <= '0;
        else if (byte_done && lstate_reg == LS_DATA && ack_ok)
        begin
            page_buf[ofs_reg] <= shift_reg;
            mask_reg[ofs_reg] <= 1'b1;
        end
    end

    always_ff @(posedge lclk)
    begin
        if (lrst_reg)
            req_tgl_reg <= 1'b0;
        else if (bus_stop && lstate_reg == LS_DATA && mask_reg != '0 && !wp_hold_reg)
            req_tgl_reg <= ~req_tgl_reg;
    end

    // =================================================================
    // Link domain: open-drain data pin
    always_ff @(posedge lclk)
    begin
        sda_out <= 1'b0;
        if (lrst_reg || bus_start || bus_stop)
            sda_oe_n <= 1'b1;
        else if (byte_done)
        begin
            // Driven only after SCL falls, held through the high phase
            sda_oe_n <= ~ack_ok;
        end
        else if (ack_end)
            sda_oe_n <= 1'b1;
    end

    // =================================================================
    // Core domain: power-up delay
    logic [PU_W-1:0]        pu_cnt_reg;

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pu_cnt_reg <= '0;
            dev_ready  <= 1'b0;
        end
        else if (pu_cnt_reg != PU_W'(PU_CYCLES))
            pu_cnt_reg <= pu_cnt_reg + 1'b1;
        else
            dev_ready <= 1'b1;
    end

    // =================================================================
    // Core domain: commit handshake and programming engine
    logic                   req_meta_reg;
    logic                   req_sync_reg;
    logic                   req_seen_reg;
    eewr_prog_state_e       pstate_reg;
    logic [`EEWR_OFS_W-1:0] copy_idx_reg;
    logic [PC_W-1:0]        prog_cnt_reg;
    // Erased content at start; a brown-out does not erase the array
    logic [7:0]             mem [0:MEM_BYTES-1] = '{default: `EEWR_ERASED};

    always_ff @(posedge mclk)
    begin
        req_meta_reg <= req_tgl_reg;
        req_sync_reg <= req_meta_reg;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            pstate_reg   <= PS_IDLE;
            req_seen_reg <= 1'b0;
            ack_tgl_reg  <= 1'b0;
            prog_busy    <= 1'b0;
            copy_idx_reg <= '0;
            prog_cnt_reg <= '0;
        end
        else
        begin
            case (pstate_reg)
                PS_IDLE:
                begin
                    if (req_sync_reg != req_seen_reg)
                    begin
                        req_seen_reg <= req_sync_reg;
                        prog_busy    <= 1'b1;
                        copy_idx_reg <= '0;
                        pstate_reg   <= PS_COPY;
                    end
                end
                PS_COPY:
                begin
                    copy_idx_reg <= copy_idx_reg + 1'b1;
                    if (copy_idx_reg == `EEWR_OFS_W'(`EEWR_PAGE_BYTES - 1))
                    begin
                        prog_cnt_reg <= '0;
                        pstate_reg   <= PS_WAIT;
                    end
                end
                PS_WAIT:
                begin
                    prog_cnt_reg <= prog_cnt_reg + 1'b1;
                    if (prog_cnt_reg == PC_W'(PROG_CYCLES - 1))
                    begin
                        prog_busy   <= 1'b0;
                        ack_tgl_reg <= ~ack_tgl_reg;
                        pstate_reg  <= PS_IDLE;
                    end
                end
                default:
                begin
                    pstate_reg <= PS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (pstate_reg == PS_COPY && mask_reg[copy_idx_reg])
            mem[{page_reg, copy_idx_reg}] <= page_buf[copy_idx_reg];
        peek_data <= mem[peek_addr];
    end

endmodule : eewr_write_path

// ### sim/eewr_write_path_monitor.sv
// Purpose: Port checks of the serial memory write path
// Assumes: Bound to every write path instance
// Notes:   Counts follow the instance parameters
module eewr_write_path_monitor
#(
    parameter int PROG_CYCLES = 500000,
    parameter int PU_CYCLES   = 100000
)
(
    // Clocks and reset
    input wire logic mclk,
    input wire logic lclk,
    input wire logic reset,
    // Bus and status
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic dev_ready,
    input wire logic prog_busy
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [19:0] rls_cnt_reg;
    logic [19:0] busy_cnt_reg;

    // =====
    // Helper counters; the release counter saturates so long defaults cannot wrap
    always_ff @(posedge mclk)
    begin
        if (reset)
            rls_cnt_reg <= 20'h0;
        else if (rls_cnt_reg != 20'hFFFFF)
            rls_cnt_reg <= rls_cnt_reg + 20'h1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset || !prog_busy)
            busy_cnt_reg <= 20'h0;
        else
            busy_cnt_reg <= busy_cnt_reg + 20'h1;
    end

    // =====
    // Assertions
    a_reset_clears: assert property (@(posedge mclk) disable iff (reset)
        $fell(reset) |-> !dev_ready && !prog_busy) else $error("status kept over reset");
    a_ready_early: assert property (@(posedge mclk) disable iff (reset)
        rls_cnt_reg < PU_CYCLES |-> !dev_ready && sda_oe_n) else $error("ready too early");
    a_busy_length: assert property (@(posedge mclk) disable iff (reset)
        $fell(prog_busy) |-> busy_cnt_reg == PROG_CYCLES + 32) else $error("busy length");
    a_busy_no_ack: assert property (@(posedge mclk) disable iff (reset)
        prog_busy |-> sda_oe_n) else $error("acknowledge while busy");
    a_commit_stop: assert property (@(posedge mclk) disable iff (reset)
        $rose(prog_busy) |-> scl_in && sda_in) else $error("commit without stop");
    a_ack_scl_low: assert property (@(posedge lclk) disable iff (reset)
        $changed(sda_oe_n) |-> !scl_in) else $error("drive change with clock high");
    a_ack_holds: assert property (@(posedge lclk) disable iff (reset)
        $fell(sda_oe_n) |-> !sda_oe_n [*8]) else $error("acknowledge too short");
    a_drive_low: assert property (@(posedge lclk) disable iff (reset)
        !sda_oe_n |-> !sda_out && !sda_in) else $error("driven line not low");

    c_commit: cover property (@(posedge mclk) disable iff (reset) $rose(prog_busy));
    c_ack: cover property (@(posedge lclk) disable iff (reset) $fell(sda_oe_n));
    c_ready: cover property (@(posedge mclk) disable iff (reset) $rose(dev_ready));
endmodule : eewr_write_path_monitor

bind eewr_write_path eewr_write_path_monitor
    #(.PROG_CYCLES(PROG_CYCLES), .PU_CYCLES(PU_CYCLES)) eewr_write_path_monitor_i
    (.mclk(mclk), .lclk(lclk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
     .sda_out(sda_out), .sda_oe_n(sda_oe_n), .dev_ready(dev_ready),
     .prog_busy(prog_busy));

// ### sim/eewr_master.sv
// Purpose: Two-wire bus master model
// Assumes: The bench resolves SDA with a pull-up
// Notes:   SCL stands high between frames
module eewr_master
#(
    parameter int Q = 250
)
(
    // Bus
    output logic     scl,
    output logic     sda_pull,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Also serves as repeated start from a low clock
    task automatic bus_start;
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask : bus_start

    task automatic bus_stop;
        sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #(4 * Q);
    endtask : bus_stop

    task automatic bus_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            sda_pull = !b[i];
            #Q scl = 1'b1;
            #(2 * Q) scl = 1'b0;
            #Q;
        end
        sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q ack = !sda;
        #Q scl = 1'b0;
        #Q;
    endtask : bus_byte
endmodule : eewr_master

// ### sim/eewr_write_path_tb.sv
// Purpose: Self-checking bench of the serial memory write path
// Assumes: Shortened power-up and programming counts
// Notes:   Read direction is expected to be refused
`include "eewr_consts.svh"

module eewr_write_path_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PROG = 1500;
    localparam int PU   = 400;

    typedef struct packed
    {
        logic [2:0] strap;
        logic [7:0] dev;
        logic       ack;
    } eewr_row_s;

    logic        mclk = 1'b0;
    logic        lclk = 1'b0;
    logic        reset = 1'b1;
    logic [2:0]  strap = 3'h0;
    logic        wp = 1'b0;
    logic [11:0] peek_addr = 12'h000;
    logic        scl, sda_pull, sda_out, sda_oe_n, dev_ready, prog_busy;
    logic [7:0]  peek_data;
    int          err_count = 0;
    int          comparisons = 0;
    wire         sda = !(sda_pull || (!sda_oe_n && !sda_out));

    // Straps, address byte, expected acknowledge
    eewr_row_s rows [8] = '{
        '{3'h0, 8'hA0, 1'b1}, '{3'h5, 8'hAA, 1'b1}, '{3'h7, 8'hAE, 1'b1},
        '{3'h2, 8'hA4, 1'b1}, '{3'h5, 8'hA0, 1'b0}, '{3'h0, 8'hA1, 1'b0},
        '{3'h0, 8'hB0, 1'b0}, '{3'h3, 8'h26, 1'b0}};

    always #5 mclk = ~mclk;

    // Offset keeps link edges away from core edges
    initial
    begin
        #2;
        forever #15 lclk = ~lclk;
    end

    eewr_master eewr_master_i (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    eewr_write_path #(.PROG_CYCLES(PROG), .PU_CYCLES(PU)) eewr_write_path_i (
        .mclk(mclk), .lclk(lclk), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .strap_addr_bit0(strap[0]),
        .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
        .write_protect(wp), .dev_ready(dev_ready), .prog_busy(prog_busy),
        .peek_addr(peek_addr), .peek_data(peek_data));

    // =====
    // Tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step

    task automatic xfer(input logic [7:0] b, input logic exp);
        logic ack;
        eewr_master_i.bus_byte(b, ack);
        check({7'h0, ack}, {7'h0, exp});
    endtask : xfer

    // Upper nibble of the high byte is don't-care
    task automatic header(input logic [11:0] a);
        eewr_master_i.bus_start;
        xfer({4'hA, strap, 1'b0}, 1'b1);
        xfer({4'hF, a[11:8]}, 1'b1);
        xfer(a[7:0], 1'b1);
    endtask : header

    task automatic peek(input logic [11:0] a, input logic [7:0] exp);
        peek_addr = a;
        step(2);
        check(peek_data, exp);
    endtask : peek

    task automatic wait_ready;
        int n;
        for (n = 0; n < 1000 && dev_ready !== 1'b1; n++)
            step(1);
        check({7'h0, dev_ready}, 8'h01);
    endtask : wait_ready

    task automatic no_commit;
        step(100);
        check({7'h0, prog_busy}, 8'h00);
    endtask : no_commit

    task automatic commit;
        int n;
        logic ack;
        for (n = 0; n < 100 && prog_busy !== 1'b1; n++)
            step(1);
        check({7'h0, prog_busy}, 8'h01);
        ack = 1'b0;
        for (n = 0; n < 20 && ack !== 1'b1; n++)
        begin
            eewr_master_i.bus_start;
            eewr_master_i.bus_byte({4'hA, strap, 1'b0}, ack);
            eewr_master_i.bus_stop;
            if (n == 0)
                check({7'h0, ack}, 8'h00);
        end
        check({7'h0, ack}, 8'h01);
        step(1);
    endtask : commit

    task automatic print_verdict;
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // =====
    // Main sequence
    initial
    begin
        step(16);
        check({6'h0, sda_oe_n, dev_ready}, 8'h02);
        reset = 1'b0;
        eewr_master_i.bus_start;
        xfer(8'hA0, 1'b0);
        eewr_master_i.bus_stop;
        wait_ready;
        foreach (rows[i])
        begin
            step(1);
            strap = rows[i].strap;
            eewr_master_i.bus_start;
            xfer(rows[i].dev, rows[i].ack);
            eewr_master_i.bus_stop;
        end
        no_commit;
        // Page write of 34 bytes from offset 1E wraps and overwrites
        header(12'h13E);
        for (int i = 0; i < 34; i++)
            xfer(8'h40 + i[7:0], 1'b1);
        peek(12'h13E, `EEWR_ERASED);
        eewr_master_i.bus_stop;
        commit;
        for (int o = 0; o < 32; o++)
            peek(12'h120 + o[11:0], 8'h42 + o[7:0]);
        peek(12'h11F, `EEWR_ERASED);
        peek(12'h140, `EEWR_ERASED);
        wp = 1'b1;
        header(12'h020);
        xfer(8'h55, 1'b0);
        eewr_master_i.bus_stop;
        no_commit;
        wp = 1'b0;
        peek(12'h020, `EEWR_ERASED);
        header(12'h020);
        xfer(8'h5A, 1'b1);
        eewr_master_i.bus_stop;
        commit;
        peek(12'h020, 8'h5A);
        // Power loss in mid-write
        header(12'h040);
        xfer(8'h33, 1'b1);
        reset = 1'b1;
        step(16);
        check({5'h0, sda_oe_n, dev_ready, prog_busy}, 8'h04);
        reset = 1'b0;
        wait_ready;
        eewr_master_i.bus_stop;
        no_commit;
        peek(12'h040, `EEWR_ERASED);
        print_verdict;
    end

    initial
    begin
        #1ms;
        err_count++;
        print_verdict;
    end
endmodule : eewr_write_path_tb
